// ==== verilog/osc_clock_defines.svh ====
// constants for the oscillator mode and clock divider block
`ifndef OSC_CLOCK_DEFINES_SVH
`define OSC_CLOCK_DEFINES_SVH

// multiplier input prescaler encodings
`define PRE_DIV12 3'h0
`define PRE_DIV10 3'h1
`define PRE_DIV6 3'h2
`define PRE_DIV5 3'h3
`define PRE_DIV4 3'h4
`define PRE_DIV3 3'h5
`define PRE_DIV2 3'h6
`define PRE_DIV1 3'h7

// prescaler terminal counts (divisor minus one)
`define PRE_LAST12 4'hB
`define PRE_LAST10 4'h9
`define PRE_LAST6 4'h5
`define PRE_LAST5 4'h4
`define PRE_LAST4 4'h3
`define PRE_LAST3 4'h2
`define PRE_LAST2 4'h1
`define PRE_LAST1 4'h0

// core clock divider encodings and terminal counts
`define CDIV_NONE 2'h3
`define CDIV_2 2'h2
`define CDIV_3 2'h1
`define CDIV_6 2'h0
`define CDIV_LAST1 3'h0
`define CDIV_LAST2 3'h1
`define CDIV_LAST3 3'h2
`define CDIV_LAST6 3'h5

// usb dividers: 48/8 = 6 from the multiplier, 24/4 = 6 without it
`define USB_LAST_FS 3'h0
`define USB_LAST_LS_MULT 3'h7
`define USB_LAST_LS_PLAIN 3'h3

// clock output toggles every second peripheral tick: period of four
`define DIVIDED_CLOCK_OUT_LAST 1'h1

// active clock source select codes
`define SRC_PRIMARY 2'h0
`define SRC_SECONDARY 2'h1

`endif

// ==== verilog/osc_clock_pkg.sv ====
// types shared by the oscillator mode and clock divider block
package osc_clock_pkg;

  // oscillator mode field, three non-volatile bits
  typedef enum logic [2:0] {
    ext_clock_with_multiplier = 3'b000,
    ext_clock_plain = 3'b001,
    crystal_with_multiplier = 3'b010,
    crystal_plain = 3'b011,
    internal_mult_with_out = 3'b100,
    internal_mult_no_out = 3'b101,
    internal_plain_with_out = 3'b110,
    internal_rc_source = 3'b111
  } osc_mode_t;

  // non-volatile configuration carried as one word
  typedef struct packed {
    osc_mode_t osc_mode_select;
    logic [2:0] multiplier_input_prescale;
    logic [1:0] core_clock_divide;
  } nv_cfg_t;

endpackage

// ==== verilog/osc_clock_divider.sv ====
// oscillator mode selection, multiplier prescaler and clock dividers
// Operation
// - Eight oscillator modes chosen by a three-bit non-volatile field.
// - Clock output runs at one quarter of the peripheral clock.
// - Clock output stops in Sleep and keeps running in Idle.
// - External clock with multiplier: clock on pin b, output, multiplier by software.
// - Plain external clock: multiplier always off, clock output still given.
// - Crystal with multiplier: crystal across both pins, multiplier by software.
// - Plain crystal: crystal across both pins, multiplier always off.
// - Internal with multiplier and output: pin a clock out, pin b port.
// - Internal with multiplier, no output: both pins are ports.
// - Internal without multiplier: multiplier off, only output variant drives pin a.
// - USB gets 6 MHz at low speed; full speed gets 48 MHz from the multiplier, or the undivided source without it.
// - Core clock path is independent of the USB clock path.
// - Multiplier gives 96 MHz; USB and core clocks derive from it.
// - Prescaler codes 000..110 divide by 12,10,6,5,4,3,2.
// - Core divider codes 11,10,01,00 divide by 1,2,3,6.
// - Mode, prescaler and divider stay fixed until reprogrammed.
// - Software tuning bit enables the multiplier where the mode allows.
// - Software select bits choose the active clock source.
// - Prescaler code 111 divides by one for a 4 MHz input.
`include "osc_clock_defines.svh"
`timescale 1ns/1ps
`default_nettype none

module osc_clock_divider (
  input wire logic clock,
  input wire logic rstn,
  input wire osc_clock_pkg::nv_cfg_t nv_config,
  input wire logic mult_sw_enable,
  input wire logic [1:0] clock_source_sel,
  input wire logic sleep_mode,
  input wire logic idle_mode,
  input wire logic usb_full_speed,
  input wire logic xtal_tick,
  input wire logic int_tick,
  input wire logic sec_tick,
  input wire logic mult_tick,
  input wire logic osc_pin_a_in,
  output logic osc_pin_a_out,
  output logic osc_pin_a_oe_n,
  input wire logic osc_pin_b_in,
  output logic osc_pin_b_out,
  output logic osc_pin_b_oe_n,
  input wire logic port_a_out,
  input wire logic port_a_oe_n,
  input wire logic port_b_out,
  input wire logic port_b_oe_n,
  output logic port_a_rd,
  output logic port_b_rd,
  output logic xtal_drive_en,
  output logic mult_ref_tick,
  output logic mult_enable,
  output logic core_tick,
  output logic periph_tick,
  output logic usb_tick,
  output logic divided_clock_out
);
  import osc_clock_pkg::*;

  // mode decoding used by several processes
  function automatic logic has_mult(osc_mode_t m);
    has_mult = (m == ext_clock_with_multiplier) ||
               (m == crystal_with_multiplier) ||
               (m == internal_mult_with_out) ||
               (m == internal_mult_no_out);
  endfunction

  function automatic logic has_divided_clock_out(osc_mode_t m);
    has_divided_clock_out = (m == ext_clock_with_multiplier) ||
               (m == ext_clock_plain) ||
               (m == internal_mult_with_out) ||
               (m == internal_plain_with_out);
  endfunction

  function automatic logic is_xtal(osc_mode_t m);
    is_xtal = (m == crystal_with_multiplier) || (m == crystal_plain);
  endfunction

  function automatic logic is_ext(osc_mode_t m);
    is_ext = (m == ext_clock_with_multiplier) || (m == ext_clock_plain);
  endfunction

  function automatic logic [3:0] pre_last(logic [2:0] code);
    unique case (code)
      `PRE_DIV12: pre_last = `PRE_LAST12;
      `PRE_DIV10: pre_last = `PRE_LAST10;
      `PRE_DIV6: pre_last = `PRE_LAST6;
      `PRE_DIV5: pre_last = `PRE_LAST5;
      `PRE_DIV4: pre_last = `PRE_LAST4;
      `PRE_DIV3: pre_last = `PRE_LAST3;
      `PRE_DIV2: pre_last = `PRE_LAST2;
      `PRE_DIV1: pre_last = `PRE_LAST1;
    endcase
  endfunction

  function automatic logic [2:0] core_last(logic [1:0] code);
    unique case (code)
      `CDIV_NONE: core_last = `CDIV_LAST1;
      `CDIV_2: core_last = `CDIV_LAST2;
      `CDIV_3: core_last = `CDIV_LAST3;
      `CDIV_6: core_last = `CDIV_LAST6;
    endcase
  endfunction

  nv_cfg_t cfg_ff;
  logic loaded_ff;
  logic mult_active_ff;
  logic pin_b_prev_ff;
  logic [3:0] pre_cnt_ff;
  logic half_ff;
  logic t48_ff;
  logic [2:0] core_cnt_ff;
  logic [2:0] usb_cnt_ff;
  logic divided_clock_out_cnt_ff;
  logic divided_clock_out_ff;
  logic core_tick_ff;
  logic periph_tick_ff;
  logic usb_tick_ff;
  logic mult_ref_ff;
  logic port_a_rd_ff;
  logic port_b_rd_ff;
  logic prim_tick;
  logic sys_tick;
  logic usb_base;
  logic [2:0] usb_last;
  logic core_wrap;

  // configuration caught once after reset release, then frozen
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      cfg_ff <= '0;
      loaded_ff <= 1'b0;
    end else if (!loaded_ff) begin
      cfg_ff <= nv_config;
      loaded_ff <= 1'b1;
    end
  end

  // multiplier only under software control in modes that have it
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      mult_active_ff <= 1'b0;
    end else begin
      mult_active_ff <= loaded_ff & has_mult(cfg_ff.osc_mode_select) &
                        mult_sw_enable;
    end
  end

  // pin b edge detect; inputs are already synchronous to clock
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      pin_b_prev_ff <= 1'b0;
    end else begin
      pin_b_prev_ff <= osc_pin_b_in;
    end
  end

  // primary source: external pin, crystal or internal postscaler
  always_comb begin
    if (!loaded_ff) begin
      prim_tick = 1'b0;
    end else if (is_ext(cfg_ff.osc_mode_select)) begin
      prim_tick = osc_pin_b_in & ~pin_b_prev_ff;
    end else if (is_xtal(cfg_ff.osc_mode_select)) begin
      prim_tick = xtal_tick;
    end else begin
      prim_tick = int_tick;
    end
  end

  // prescaler ahead of the multiplier reference input
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      pre_cnt_ff <= 4'h0;
      mult_ref_ff <= 1'b0;
    end else begin
      mult_ref_ff <= 1'b0;
      if (!mult_active_ff) begin
        pre_cnt_ff <= 4'h0;
      end else if (prim_tick) begin
        if (pre_cnt_ff == pre_last(cfg_ff.multiplier_input_prescale)) begin
          pre_cnt_ff <= 4'h0;
          mult_ref_ff <= 1'b1;
        end else begin
          pre_cnt_ff <= pre_cnt_ff + 4'h1;
        end
      end
    end
  end

  // 96 MHz events halved to the 48 MHz stream
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      half_ff <= 1'b0;
      t48_ff <= 1'b0;
    end else begin
      t48_ff <= mult_active_ff & mult_tick & half_ff;
      if (!mult_active_ff) begin
        half_ff <= 1'b0;
      end else if (mult_tick) begin
        half_ff <= ~half_ff;
      end
    end
  end

  // active source mux; secondary and internal bypass the multiplier but still pass the core divider
  always_comb begin
    if (!loaded_ff) begin
      sys_tick = 1'b0;
    end else if (clock_source_sel == `SRC_PRIMARY) begin
      sys_tick = mult_active_ff ? t48_ff : prim_tick;
    end else if (clock_source_sel == `SRC_SECONDARY) begin
      sys_tick = sec_tick;
    end else begin
      sys_tick = int_tick;
    end
  end

  assign core_wrap = core_cnt_ff == core_last(cfg_ff.core_clock_divide);

  // core divider; frozen in sleep so the phase survives a wake-up
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      core_cnt_ff <= 3'h0;
    end else if (sys_tick && !sleep_mode) begin
      if (core_wrap) begin
        core_cnt_ff <= 3'h0;
      end else begin
        core_cnt_ff <= core_cnt_ff + 3'h1;
      end
    end
  end

  // peripheral clock runs in idle, core clock does not
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      periph_tick_ff <= 1'b0;
      core_tick_ff <= 1'b0;
    end else begin
      periph_tick_ff <= sys_tick & core_wrap & ~sleep_mode;
      core_tick_ff <= sys_tick & core_wrap & ~sleep_mode & ~idle_mode;
    end
  end

  // usb path fed straight from the source, not from the core divider
  assign usb_base = mult_active_ff ? t48_ff : prim_tick;
  always_comb begin
    if (usb_full_speed) begin
      usb_last = `USB_LAST_FS;
    end else if (mult_active_ff) begin
      usb_last = `USB_LAST_LS_MULT;
    end else begin
      usb_last = `USB_LAST_LS_PLAIN;
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      usb_cnt_ff <= 3'h0;
      usb_tick_ff <= 1'b0;
    end else begin
      usb_tick_ff <= 1'b0;
      if (usb_base) begin
        if (usb_cnt_ff >= usb_last) begin
          usb_cnt_ff <= 3'h0;
          usb_tick_ff <= 1'b1;
        end else begin
          usb_cnt_ff <= usb_cnt_ff + 3'h1;
        end
      end
    end
  end

  // clock output: toggles every second peripheral tick, none in sleep
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      divided_clock_out_cnt_ff <= 1'b0;
      divided_clock_out_ff <= 1'b0;
    end else if (periph_tick_ff) begin
      if (divided_clock_out_cnt_ff == `DIVIDED_CLOCK_OUT_LAST) begin
        divided_clock_out_cnt_ff <= 1'b0;
        divided_clock_out_ff <= ~divided_clock_out_ff;
      end else begin
        divided_clock_out_cnt_ff <= divided_clock_out_cnt_ff + 1'b1;
      end
    end
  end

  // pin readback towards the port logic
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      port_a_rd_ff <= 1'b0;
      port_b_rd_ff <= 1'b0;
    end else begin
      port_a_rd_ff <= osc_pin_a_in;
      port_b_rd_ff <= osc_pin_b_in;
    end
  end

  // pin ownership per mode; crystal pins are released to the amplifier
  always_comb begin
    osc_pin_a_out = 1'b0;
    osc_pin_a_oe_n = 1'b1;
    osc_pin_b_out = 1'b0;
    osc_pin_b_oe_n = 1'b1;
    if (!loaded_ff || is_xtal(cfg_ff.osc_mode_select)) begin
      osc_pin_a_oe_n = 1'b1;
    end else begin
      if (has_divided_clock_out(cfg_ff.osc_mode_select)) begin
        osc_pin_a_out = divided_clock_out_ff;
        osc_pin_a_oe_n = 1'b0;
      end else begin
        osc_pin_a_out = port_a_out;
        osc_pin_a_oe_n = port_a_oe_n;
      end
      if (!is_ext(cfg_ff.osc_mode_select)) begin
        osc_pin_b_out = port_b_out;
        osc_pin_b_oe_n = port_b_oe_n;
      end
    end
  end

  assign xtal_drive_en = loaded_ff & is_xtal(cfg_ff.osc_mode_select);
  assign mult_ref_tick = mult_ref_ff;
  assign mult_enable = mult_active_ff;
  assign core_tick = core_tick_ff;
  assign periph_tick = periph_tick_ff;
  assign usb_tick = usb_tick_ff;
  assign divided_clock_out = divided_clock_out_ff;
  assign port_a_rd = port_a_rd_ff;
  assign port_b_rd = port_b_rd_ff;

  // helper: peripheral ticks seen since the last clock output edge
  logic [2:0] chk_ticks_ff;
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      chk_ticks_ff <= 3'h0;
    end else if (divided_clock_out_ff != $past(divided_clock_out_ff)) begin
      chk_ticks_ff <= {2'h0, periph_tick_ff};
    end else if (periph_tick_ff && chk_ticks_ff != 3'h7) begin
      chk_ticks_ff <= chk_ticks_ff + 3'h1;
    end
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (!rstn);

  property p_plain_no_mult;
    loaded_ff && !has_mult(cfg_ff.osc_mode_select) |=> !mult_enable;
  endproperty
  a_plain_no_mult: assert property (p_plain_no_mult)
    else $error("multiplier active in a mode without it");

  property p_sw_mult;
    loaded_ff && has_mult(cfg_ff.osc_mode_select) && mult_sw_enable
      |=> mult_enable;
  endproperty
  a_sw_mult: assert property (p_sw_mult)
    else $error("software enable did not start the multiplier");

  property p_cfg_frozen;
    loaded_ff |=> $stable(cfg_ff);
  endproperty
  a_cfg_frozen: assert property (p_cfg_frozen)
    else $error("configuration changed after load");

  property p_divided_clock_out_sleep;
    sleep_mode ##1 sleep_mode |=> $stable(divided_clock_out);
  endproperty
  a_divided_clock_out_sleep: assert property (p_divided_clock_out_sleep)
    else $error("clock output toggled in sleep");

  property p_divided_clock_out_quarter;
    loaded_ff && $changed(divided_clock_out) && $past(loaded_ff, 2)
      |-> $past(chk_ticks_ff) == 3'h1 || $past(chk_ticks_ff) == 3'h2;
  endproperty
  a_divided_clock_out_quarter: assert property (p_divided_clock_out_quarter)
    else $error("clock output half period is not two ticks");

  property p_pin_a_divided_clock_out;
    loaded_ff && has_divided_clock_out(cfg_ff.osc_mode_select)
      |-> !osc_pin_a_oe_n && osc_pin_a_out == divided_clock_out;
  endproperty
  a_pin_a_divided_clock_out: assert property (p_pin_a_divided_clock_out)
    else $error("pin a not driving the clock output");

  property p_port_pins;
    loaded_ff && cfg_ff.osc_mode_select == internal_mult_no_out
      |-> osc_pin_a_oe_n == port_a_oe_n && osc_pin_b_oe_n == port_b_oe_n;
  endproperty
  a_port_pins: assert property (p_port_pins)
    else $error("port function lost on oscillator pins");

  property p_xtal_pins;
    loaded_ff && is_xtal(cfg_ff.osc_mode_select)
      |-> xtal_drive_en && osc_pin_a_oe_n && osc_pin_b_oe_n;
  endproperty
  a_xtal_pins: assert property (p_xtal_pins)
    else $error("crystal pins not released to the amplifier");

  property p_prescale;
    mult_ref_tick |-> $past(prim_tick) &&
      $past(pre_cnt_ff) == pre_last(cfg_ff.multiplier_input_prescale);
  endproperty
  a_prescale: assert property (p_prescale)
    else $error("prescaler wrapped at the wrong count");

  property p_half;
    t48_ff |=> !t48_ff [*1] ##0 !$past(half_ff) || !$past(mult_tick);
  endproperty
  a_half: assert property (p_half)
    else $error("48 MHz stream not half of the multiplier");

  property p_core_none;
    cfg_ff.core_clock_divide == `CDIV_NONE && sys_tick && !sleep_mode
      |=> periph_tick;
  endproperty
  a_core_none: assert property (p_core_none)
    else $error("undivided core path dropped a tick");

  c_mult_core: cover property (mult_enable && core_tick);
  c_divided_clock_out_rise: cover property (!divided_clock_out ##1 divided_clock_out);
  c_usb_fs: cover property (usb_full_speed && usb_tick);
  c_idle_periph: cover property (idle_mode && periph_tick);

endmodule

`default_nettype wire

// ==== verif/osc_source_model.sv ====
// external clock source, crystal pulses and multiplier output stand-in
`timescale 1ns/1ps
`default_nettype none

module osc_source_model (
  input wire logic clock,
  input wire logic rstn,
  input wire logic run,
  input wire logic [1:0] rnd,
  input wire logic mult_on,
  output logic pin_b_clk,
  output logic src_tick,
  output logic mult_tick,
  output int edges,
  output int mults
);
  initial begin
    pin_b_clk = 1'b0;
    src_tick = 1'b0;
    mult_tick = 1'b0;
  end

  // source steps at random; it stands still outside a run so counts stay exact
  always @(negedge clock) begin
    src_tick <= 1'b0;
    mult_tick <= 1'b0;
    if (!rstn) begin
      edges <= 0;
      mults <= 0;
    end else begin
      if (run && rnd[0]) begin
        pin_b_clk <= !pin_b_clk;
        if (!pin_b_clk) begin
          src_tick <= 1'b1;
          edges <= edges + 1;
        end
      end
      // multiplier events only while the block turns it on, back to back too
      if (mult_on && run && rnd[1]) begin
        mult_tick <= 1'b1;
        mults <= mults + 1;
      end
    end
  end
endmodule

`default_nettype wire

// ==== verif/oscillator_mode_and_clock_divider_test.sv ====
// self-checking bench for the oscillator mode and clock divider block
`timescale 1ns/1ps
`default_nettype none

module oscillator_mode_and_clock_divider_test;
  import osc_clock_pkg::*;
  logic clock, rstn, mult_sw_enable, sleep_mode, idle_mode, usb_full_speed;
  logic [1:0] clock_source_sel;
  nv_cfg_t nv_config;
  logic sec_tick, osc_pin_a_in, osc_pin_b_in;
  logic port_a_out, port_a_oe_n, port_b_out, port_b_oe_n;
  logic osc_pin_a_out, osc_pin_a_oe_n, osc_pin_b_out, osc_pin_b_oe_n;
  logic port_a_rd, port_b_rd, xtal_drive_en, mult_ref_tick, mult_enable;
  logic core_tick, periph_tick, usb_tick, divided_clock_out;
  logic run, pin_b_clk, src_tick, mult_tick, prev_divided_clock_out, pll, outm;
  logic [1:0] rnd;
  logic [31:0] seed;
  int edges, mults, n_core, n_per, n_usb, n_ref, n_flip, n_sec;
  int fails, cmp_count, cycles, base;
  int pdiv[8] = '{12, 10, 6, 5, 4, 3, 2, 1};
  int cdiv[4] = '{6, 3, 2, 1};

  // pins settle from whoever drives them; an undriven pin a shows the
  // crystal's opposite side rather than a stale value
  assign osc_pin_b_in = osc_pin_b_oe_n ? pin_b_clk : osc_pin_b_out;
  assign osc_pin_a_in = osc_pin_a_oe_n ? !pin_b_clk : osc_pin_a_out;

  osc_clock_divider uut (
    .clock, .rstn, .nv_config, .mult_sw_enable, .clock_source_sel,
    .sleep_mode, .idle_mode, .usb_full_speed, .xtal_tick(src_tick),
    .int_tick(src_tick), .sec_tick, .mult_tick, .osc_pin_a_in,
    .osc_pin_a_out, .osc_pin_a_oe_n, .osc_pin_b_in, .osc_pin_b_out,
    .osc_pin_b_oe_n, .port_a_out, .port_a_oe_n, .port_b_out, .port_b_oe_n,
    .port_a_rd, .port_b_rd, .xtal_drive_en, .mult_ref_tick, .mult_enable,
    .core_tick, .periph_tick, .usb_tick, .divided_clock_out
  );

  osc_source_model src (
    .clock, .rstn, .run, .rnd, .mult_on(mult_enable), .pin_b_clk,
    .src_tick, .mult_tick, .edges, .mults
  );

  function automatic logic [31:0] xs(input logic [31:0] v);
    logic [31:0] x;
    x = v ^ (v << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      fails++;
      $display("unexpected at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask

  task automatic conclude;
    $display("comparisons %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // each test reloads the config through reset, then scrambles it
  task automatic start(input nv_cfg_t cfg, input logic sw, input logic fs);
    @(negedge clock);
    rstn <= 1'b0;
    run <= 1'b0;
    nv_config <= cfg;
    mult_sw_enable <= sw;
    usb_full_speed <= fs;
    sleep_mode <= 1'b0;
    idle_mode <= 1'b0;
    clock_source_sel <= 2'h0;
    {port_a_out, port_a_oe_n, port_b_out, port_b_oe_n} <= seed[7:4];
    repeat (6) @(negedge clock);
    rstn <= 1'b1;
    @(negedge clock);
    nv_config <= nv_cfg_t'(~cfg);
  endtask

  // run the sources, then let the divider pipelines drain
  task automatic traffic(input int n);
    run <= 1'b1;
    repeat (n) @(negedge clock);
    run <= 1'b0;
    repeat (12) @(negedge clock);
  endtask

  initial begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end

  // random steps reach the source model and the secondary tick input
  always @(negedge clock) begin
    seed <= xs(seed);
    rnd <= seed[1:0];
    sec_tick <= run & seed[2];
  end

  // output pulses stand one cycle, so every edge is counted
  always @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      {n_core, n_per, n_usb, n_ref, n_flip, n_sec} <= 192'h0;
      prev_divided_clock_out <= 1'b0;
    end else begin
      n_core <= n_core + core_tick;
      n_per <= n_per + periph_tick;
      n_usb <= n_usb + usb_tick;
      n_ref <= n_ref + mult_ref_tick;
      n_flip <= n_flip + (divided_clock_out != prev_divided_clock_out);
      n_sec <= n_sec + sec_tick;
      prev_divided_clock_out <= divided_clock_out;
    end
  end

  // a hang is cut short well past the expected run length
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 40000) begin
      fails++;
      conclude();
    end
  end

  initial begin
    {rstn, run, sec_tick, mult_sw_enable, sleep_mode, idle_mode} = 6'h00;
    {usb_full_speed, port_a_out, port_a_oe_n, port_b_out} = 4'h0;
    port_b_oe_n = 1'b1;
    clock_source_sel = 2'h0;
    nv_config = '0;
    rnd = 2'h0;
    seed = 32'hA90FAA45;
    {fails, cmp_count, cycles} = 96'h0;
    // every mode with the multiplier requested by software
    for (int m = 0; m < 8; m++) begin
      pll = (m == 0 || m == 2 || m == 4 || m == 5);
      outm = (m == 0 || m == 1 || m == 4 || m == 6);
      start('{osc_mode_t'(m), 3'h7, 2'h3}, 1'b1, 1'b1);
      traffic(200);
      base = pll ? mults / 2 : edges;
      check(mult_enable, pll);
      check(n_core, base);
      check(n_per, base);
      check(n_usb, base);
      check(xtal_drive_en, m == 2 || m == 3);
      // pins are frozen after the drain, so readback must match them
      check(port_a_rd, osc_pin_a_in);
      check(port_b_rd, osc_pin_b_in);
      if (m < 2) check(osc_pin_b_oe_n, 1'b1);
      if (outm) begin
        check(osc_pin_a_oe_n, 1'b0);
        check(osc_pin_a_out, divided_clock_out);
        check(n_flip, base / 2);
      end
      if (m == 5 || m == 7) check({osc_pin_a_oe_n, osc_pin_a_out},
        {port_a_oe_n, port_a_out});
      if (m >= 4) check({osc_pin_b_oe_n, osc_pin_b_out},
        {port_b_oe_n, port_b_out});
      $display("mode %0d done", m);
    end
    // prescaler codes ahead of the multiplier, core and usb kept apart
    for (int p = 0; p < 8; p++) begin
      start('{ext_clock_with_multiplier, p[2:0], 2'h0}, 1'b1, 1'b0);
      traffic(300);
      check(n_ref, edges / pdiv[p]);
      check(n_core, mults / 2 / 6);
      check(n_usb, mults / 2 / 8);
      $display("prescale %0d done", p);
    end
    // core divider codes without the multiplier, low-speed usb
    for (int c = 0; c < 4; c++) begin
      start('{ext_clock_plain, 3'h0, c[1:0]}, 1'b1, 1'b0);
      traffic(300);
      check(n_core, edges / cdiv[c]);
      check(n_usb, edges / 4);
      check(mult_enable, 1'b0);
      $display("core divide %0d done", c);
    end
    // sleep freezes peripheral ticks and the clock output, usb keeps going
    start('{ext_clock_plain, 3'h0, 2'h3}, 1'b0, 1'b1);
    sleep_mode <= 1'b1;
    traffic(150);
    check(n_per, 0);
    check(n_flip, 0);
    check(n_usb, edges);
    $display("sleep done");
    // idle stops only the core
    start('{ext_clock_plain, 3'h0, 2'h3}, 1'b0, 1'b1);
    idle_mode <= 1'b1;
    traffic(200);
    check(n_core, 0);
    check(n_per, edges);
    check(n_flip, edges / 2);
    $display("power modes done");
    // secondary source selected by software
    start('{ext_clock_plain, 3'h0, 2'h3}, 1'b0, 1'b1);
    clock_source_sel <= 2'h1;
    traffic(200);
    check(n_core, n_sec);
    // internal source select: the internal tick follows the model's edges
    start('{ext_clock_plain, 3'h0, 2'h3}, 1'b0, 1'b1);
    clock_source_sel <= 2'h2;
    traffic(200);
    check(n_core, edges);
    $display("source select done");
    conclude();
  end
endmodule

`default_nettype wire
